// ---- hw/smp_map.svh ----
// Constants for the message parser: sizes, character codes and error codes.
// Behaviour
// - Log error for any unrecognized command string portion; the code takes any keyword after an asterisk without error.
// - Keep errors stored until error query reads them.
// - Header is colon-joined keywords, optional leading colon.
// - Message is semicolon-separated units plus terminator.
// - Terminator returns tree position to root.
// - Semicolon then colon restarts at root; else subsystem.
// - One space separates header from parameter data.
// - Line feed, end signal, or both terminate.
// - End signal releases buffer; bare line feed waits.
// - Settable leaf accepts query form, question mark appended.
// - Query parameters follow question mark and one space.
// - Frequency query answers exponent-form float in hertz; the parser only raises freq_rsp_req.
// - Query-only headers are rejected as commands.
// - Missing subsystem keyword implies the source subsystem.
// - Only exact long or short keyword, any case; the code accepts any keyword after an asterisk.
// - Asterisk common commands leave subsystem position unchanged.
`ifndef SMP_MAP_SVH
`define SMP_MAP_SVH
`define SMP_BUF_DEPTH  5'h10
`define SMP_BUF_AW     4
`define SMP_KW_MAX     4'hc
`define SMP_ERRQ_DEPTH 4'h8
`define SMP_ERRQ_AW    3
`define SMP_CH_LF      8'h0a
`define SMP_CH_SPACE   8'h20
`define SMP_CH_STAR    8'h2a
`define SMP_CH_COLON   8'h3a
`define SMP_CH_SEMI    8'h3b
`define SMP_CH_QMARK   8'h3f
`define SMP_CH_DIG0    8'h30
`define SMP_CH_DIG9    8'h39
`define SMP_CH_UP_A    8'h41
`define SMP_CH_UP_Z    8'h5a
`define SMP_CH_LO_A    8'h61
`define SMP_CH_LO_Z    8'h7a
`define SMP_CH_CASE    8'h20
`define SMP_ERR_NONE   8'h00
`define SMP_ERR_SYNTAX 8'h01
`define SMP_ERR_HEADER 8'h02
`define SMP_ERR_QONLY  8'h03
`endif

// ---- hw/smp_pkg.sv ----
// Types shared by the message parser modules.
package smp_pkg;
  // Position in the command tree; n_bad marks an unresolvable keyword.
  typedef enum logic [2:0] {n_root, n_sour, n_freq, n_cw, n_syst, n_err, n_common, n_bad}
    smp_node_t;
  // Lexer states of the parser.
  typedef enum {st_start, st_colon, st_kw, st_qmark, st_data, st_skip} smp_state_t;
endpackage : smp_pkg

// ---- hw/smp_kw_match.sv ----
// Case-folded keyword comparator for one long/short keyword pair.
`timescale 1ns/1ps
`default_nettype none
module smp_kw_match #(
  parameter logic [95:0] TXT  = 96'h0,
  parameter int          LLEN = 1,
  parameter int          SLEN = 1
) (
  input  wire logic [11:0][7:0] kw,
  input  wire logic [3:0]       kw_len,
  input  wire logic             kw_long,
  output logic                  hit
);
  // The short form is the leading part of the long form, so one prefix
  // compare covers both; only the two exact lengths are accepted.
  always_comb
  begin
    logic eq;
    int   sh;
    eq = 1'b1;
    sh = 0;
    for (int i = 0; i < 12; i++)
    begin
      sh = LLEN - 1 - i;
      if (i < int'(kw_len) && sh >= 0)
      begin
        if (kw[i] != TXT[8 * sh +: 8])
        begin
          eq = 1'b0;
        end
      end
    end
    hit = !kw_long && eq && (kw_len == 4'(LLEN) || kw_len == 4'(SLEN));
  end
endmodule : smp_kw_match
`default_nettype wire

// ---- hw/smp_message_parser.sv ----
// Program message parser: input buffer, header lexer, tree walk and error queue.
`timescale 1ns/1ps
`default_nettype none
`include "smp_map.svh"
module smp_message_parser
  import smp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       in_valid,
  input  wire logic [7:0] in_byte,
  input  wire logic       in_eom,
  output logic            in_ready,
  output logic            unit_valid,
  output var smp_node_t   unit_node,
  output logic            unit_query,
  output logic            unit_has_data,
  output logic            data_valid,
  output logic [7:0]      data_byte,
  output logic            freq_rsp_req,
  output logic            err_rsp_valid,
  output logic [7:0]      err_rsp_code,
  output logic [3:0]      err_count
);
  // Input buffer storage; bit 8 carries the end-of-message flag.
  logic [8:0]             buf_ff [16];
  logic [3:0]             wr_ptr_ff;
  logic [3:0]             rd_ptr_ff;
  logic [4:0]             cnt_ff;
  logic                   rel_ff;      // Buffer released to the parser.
  logic                   pend_ff;     // Synthetic terminator after an end flag.
  // Parser state.
  smp_state_t             state_ff, nxt_state;
  smp_node_t              cur_ff, nxt_cur;
  smp_node_t              base_ff, nxt_base;
  logic [11:0][7:0]       kw_ff, nxt_kw;
  logic [3:0]             len_ff, nxt_len;
  logic                   long_ff, nxt_long;
  logic                   query_ff, nxt_query;
  logic                   common_ff, nxt_common;
  // Error queue.
  logic [7:0]             eq_ff [8];
  logic [2:0]             ewr_ff;
  logic [2:0]             erd_ff;
  logic [3:0]             ecnt_ff;
  // Combinational results of one parser step.
  logic                   err_push;
  logic [7:0]             err_code;
  logic                   emit;
  smp_node_t              emit_node;
  logic                   emit_query;
  logic                   data_out;
  logic                   delim;

  // Buffer handshake; the parser never stalls on the output side.
  wire logic       push     = in_valid && in_ready;
  wire logic       pop      = rel_ff && cnt_ff != 5'h0 && !pend_ff;
  wire logic [4:0] cnt_nxt  = 5'(cnt_ff + {4'h0, push} - {4'h0, pop});
  wire logic [8:0] head     = buf_ff[rd_ptr_ff];
  assign in_ready = cnt_ff != `SMP_BUF_DEPTH;

  // A bare line feed is held until the buffer fills; the end flag frees it at once.
  wire logic rel_set = (push && in_eom) || cnt_nxt == `SMP_BUF_DEPTH;

  // An end flag on a byte that is not a line feed injects one terminator next.
  wire logic pend_set = pop && head[8] && head[7:0] != `SMP_CH_LF;

  // Byte under the parser and its character class.
  wire logic       act      = pend_ff || pop;
  wire logic [7:0] ch       = pend_ff ? `SMP_CH_LF : head[7:0];
  wire logic       is_lower = ch >= `SMP_CH_LO_A && ch <= `SMP_CH_LO_Z;
  wire logic [7:0] up       = is_lower ? ch - `SMP_CH_CASE : ch;
  wire logic       is_alnum = (up >= `SMP_CH_UP_A && up <= `SMP_CH_UP_Z)
                            || (up >= `SMP_CH_DIG0 && up <= `SMP_CH_DIG9);
  wire logic       is_term  = ch == `SMP_CH_LF;
  wire logic       is_semi  = ch == `SMP_CH_SEMI;
  wire logic       is_colon = ch == `SMP_CH_COLON;
  wire logic       is_q     = ch == `SMP_CH_QMARK;
  wire logic       is_sp    = ch == `SMP_CH_SPACE;
  wire logic       is_star  = ch == `SMP_CH_STAR;
  wire logic       is_end   = is_semi || is_term;

  // Keyword comparators, one per keyword that the tree knows.
  localparam logic [95:0] KW_TXT [6] = '{"SOURCE", "FREQUENCY", "CW", "FIXED", "SYSTEM", "ERROR"};
  localparam int          KW_LL  [6] = '{6, 9, 2, 5, 6, 5};
  localparam int          KW_SL  [6] = '{4, 4, 2, 3, 4, 3};
  logic [5:0]             hits;
  genvar g;
  generate
    for (g = 0; g < 6; g++)
    begin : g_kw
      smp_kw_match #(.TXT(KW_TXT[g]), .LLEN(KW_LL[g]), .SLEN(KW_SL[g])) u_match (
        .kw      (kw_ff),
        .kw_len  (len_ff),
        .kw_long (long_ff),
        .hit     (hits[g])
      );
    end
  endgenerate

  // Resolve the finished keyword against the current node. Frequency at the
  // root lands under the implied source subsystem.
  wire smp_node_t res = common_ff ? n_common
    : (cur_ff == n_root && hits[0]) ? n_sour
    : ((cur_ff == n_root || cur_ff == n_sour) && hits[1]) ? n_freq
    : (cur_ff == n_freq && (hits[2] || hits[3])) ? n_cw
    : (cur_ff == n_root && hits[4]) ? n_syst
    : (cur_ff == n_syst && hits[5]) ? n_err : n_bad;

  // A colon may only follow a branch keyword; common headers have no branches.
  wire logic col_ok = res == n_sour || res == n_freq || res == n_syst;

  // Leaf check: the error leaf exists only as a query.
  wire logic [7:0] leaf_code = (res == n_common || res == n_freq || res == n_cw)
    ? `SMP_ERR_NONE
    : (res == n_err) ? (is_q ? `SMP_ERR_NONE : `SMP_ERR_QONLY)
    : `SMP_ERR_HEADER;

  // One parser step per byte taken from the buffer.
  always_comb
  begin
    nxt_state  = state_ff;
    nxt_cur    = cur_ff;
    nxt_base   = base_ff;
    nxt_kw     = kw_ff;
    nxt_len    = len_ff;
    nxt_long   = long_ff;
    nxt_query  = query_ff;
    nxt_common = common_ff;
    err_push   = 1'b0;
    err_code   = `SMP_ERR_NONE;
    emit       = 1'b0;
    emit_node  = res;
    emit_query = query_ff;
    data_out   = 1'b0;
    delim      = 1'b0;
    if (act)
    begin
      unique case (state_ff)
        // Start of a unit: leading colon, common header, keyword or empty message.
        st_start:
          if (is_colon)
          begin
            nxt_cur   = n_root;
            nxt_state = st_colon;
          end
          else if (is_star)
          begin
            nxt_common = 1'b1;
            nxt_state  = st_colon;
          end
          else if (is_alnum)
          begin
            nxt_kw[0] = up;
            nxt_len   = 4'h1;
            nxt_state = st_kw;
          end
          else if (is_term)
          begin
            delim = 1'b1;
          end
          else
          begin
            err_push = 1'b1;
            err_code = `SMP_ERR_SYNTAX;
          end
        // After a colon only a keyword character may come; a space is an error.
        st_colon:
          if (is_alnum)
          begin
            nxt_kw[0] = up;
            nxt_len   = 4'h1;
            nxt_state = st_kw;
          end
          else
          begin
            err_push = 1'b1;
            err_code = `SMP_ERR_SYNTAX;
          end
        // Inside a keyword: collect characters, then act on the delimiter.
        st_kw:
          if (is_alnum)
          begin
            if (len_ff < `SMP_KW_MAX)
            begin
              nxt_kw[len_ff] = up;
              nxt_len        = len_ff + 4'h1;
            end
            else
            begin
              nxt_long = 1'b1;
            end
          end
          else if (is_colon && col_ok)
          begin
            nxt_cur   = res;
            nxt_len   = 4'h0;
            nxt_state = st_colon;
          end
          else if ((is_q || is_sp || is_end) && leaf_code == `SMP_ERR_NONE)
          begin
            nxt_cur   = res;
            nxt_query = is_q;
            if (is_q)
            begin
              nxt_state = st_qmark;
            end
            else if (is_sp)
            begin
              nxt_state = st_data;
            end
            else
            begin
              emit       = 1'b1;
              emit_query = 1'b0;
              delim      = 1'b1;
            end
          end
          else
          begin
            err_push = 1'b1;
            err_code = (is_colon || is_q || is_sp || is_end)
                     ? (is_colon ? `SMP_ERR_HEADER : leaf_code) : `SMP_ERR_SYNTAX;
          end
        // After a question mark: one space before data, or the unit ends.
        st_qmark:
          if (is_sp)
          begin
            nxt_state = st_data;
          end
          else if (is_end)
          begin
            emit      = 1'b1;
            emit_node = cur_ff;
            delim     = 1'b1;
          end
          else
          begin
            err_push = 1'b1;
            err_code = `SMP_ERR_SYNTAX;
          end
        // Parameter data passes straight out until the unit ends.
        st_data:
          if (is_end)
          begin
            emit      = 1'b1;
            emit_node = cur_ff;
            delim     = 1'b1;
          end
          else
          begin
            data_out = 1'b1;
          end
        // After an error the rest of the unit is dropped.
        st_skip:
          delim = is_end;
      endcase
      // An error ends the unit at once if it came on a delimiter.
      if (err_push)
      begin
        nxt_state = st_skip;
        delim     = is_end;
      end
      // A successful tree unit sets the subsystem for the next unit.
      if (emit && emit_node != n_common)
      begin
        nxt_base = (emit_node == n_err) ? n_syst : n_sour;
      end
      // Unit separator or terminator: reset the header collector.
      if (delim)
      begin
        nxt_state  = st_start;
        nxt_len    = 4'h0;
        nxt_long   = 1'b0;
        nxt_query  = 1'b0;
        nxt_common = 1'b0;
        nxt_cur    = is_term ? n_root : nxt_base;
        if (is_term)
        begin
          nxt_base = n_root;
        end
      end
    end
  end

  // Error queue moves; a full queue drops new entries unless one leaves.
  wire logic err_pop = emit && emit_node == n_err && emit_query;
  wire logic eq_pop  = err_pop && ecnt_ff != 4'h0;
  wire logic eq_push = err_push && (ecnt_ff != `SMP_ERRQ_DEPTH || eq_pop);

  // Input buffer and release flag.
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      buf_ff[wr_ptr_ff] <= {in_eom, in_byte};
    end
    if (reset)
    begin
      wr_ptr_ff <= 4'h0;
      rd_ptr_ff <= 4'h0;
      cnt_ff    <= 5'h0;
      rel_ff    <= 1'b0;
      pend_ff   <= 1'b0;
    end
    else
    begin
      wr_ptr_ff <= wr_ptr_ff + {3'h0, push};
      rd_ptr_ff <= rd_ptr_ff + {3'h0, pop};
      cnt_ff    <= cnt_nxt;
      rel_ff    <= rel_set || (rel_ff && cnt_nxt != 5'h0);
      pend_ff   <= pend_set;
    end
  end

  // Parser registers.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_ff  <= st_start;
      cur_ff    <= n_root;
      base_ff   <= n_root;
      kw_ff     <= '0;
      len_ff    <= 4'h0;
      long_ff   <= 1'b0;
      query_ff  <= 1'b0;
      common_ff <= 1'b0;
    end
    else
    begin
      state_ff  <= nxt_state;
      cur_ff    <= nxt_cur;
      base_ff   <= nxt_base;
      kw_ff     <= nxt_kw;
      len_ff    <= nxt_len;
      long_ff   <= nxt_long;
      query_ff  <= nxt_query;
      common_ff <= nxt_common;
    end
  end

  // Error queue and registered outputs.
  always_ff @(posedge clk)
  begin
    if (eq_push)
    begin
      eq_ff[ewr_ff] <= err_code;
    end
    if (reset)
    begin
      ewr_ff        <= 3'h0;
      erd_ff        <= 3'h0;
      ecnt_ff       <= 4'h0;
      unit_valid    <= 1'b0;
      unit_node     <= n_root;
      unit_query    <= 1'b0;
      unit_has_data <= 1'b0;
      data_valid    <= 1'b0;
      data_byte     <= 8'h00;
      freq_rsp_req  <= 1'b0;
      err_rsp_valid <= 1'b0;
      err_rsp_code  <= 8'h00;
    end
    else
    begin
      ewr_ff        <= ewr_ff + {2'h0, eq_push};
      erd_ff        <= erd_ff + {2'h0, eq_pop};
      ecnt_ff       <= 4'(ecnt_ff + {3'h0, eq_push} - {3'h0, eq_pop});
      unit_valid    <= emit;
      unit_node     <= emit ? emit_node : unit_node;
      unit_query    <= emit && emit_query;
      unit_has_data <= emit && state_ff == st_data;
      data_valid    <= data_out;
      data_byte     <= data_out ? ch : data_byte;
      freq_rsp_req  <= emit && emit_query && (emit_node == n_freq || emit_node == n_cw);
      err_rsp_valid <= err_pop;
      err_rsp_code  <= (ecnt_ff != 4'h0) ? eq_ff[erd_ff] : `SMP_ERR_NONE;
    end
  end
  assign err_count = ecnt_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_bad_logged;
    act && state_ff == st_kw && !is_alnum && res == n_bad |-> err_push;
  endproperty
  a_bad_logged: assert property (p_bad_logged) else $error("bad keyword not logged");
  property p_err_kept;
    !err_pop |=> ecnt_ff >= $past(ecnt_ff);
  endproperty
  a_err_kept: assert property (p_err_kept) else $error("error lost without query");
  property p_space_colon;
    act && state_ff == st_colon && is_sp |=> ecnt_ff != 4'h0 && state_ff != st_kw;
  endproperty
  a_space_colon: assert property (p_space_colon) else $error("space after colon accepted");
  property p_term_root;
    act && is_term |=> base_ff == n_root && cur_ff == n_root && state_ff == st_start;
  endproperty
  a_term_root: assert property (p_term_root) else $error("terminator left tree position");
  property p_eom_release;
    push && in_eom |=> rel_ff;
  endproperty
  a_eom_release: assert property (p_eom_release) else $error("end flag did not release");
  property p_eom_term;
    pend_set |=> pend_ff && act && is_term ##1 !pend_ff;
  endproperty
  a_eom_term: assert property (p_eom_term) else $error("end flag did not terminate");
  property p_qonly;
    act && state_ff == st_kw && is_end && res == n_err |-> err_push && err_code == `SMP_ERR_QONLY;
  endproperty
  a_qonly: assert property (p_qonly) else $error("query-only header taken as command");
  property p_common_keep;
    emit && emit_node == n_common && !is_term |=> base_ff == $past(base_ff);
  endproperty
  a_common_keep: assert property (p_common_keep) else $error("common header moved subsystem");
  property p_empty_none;
    err_pop && ecnt_ff == 4'h0 |=> err_rsp_valid && err_rsp_code == `SMP_ERR_NONE;
  endproperty
  a_empty_none: assert property (p_empty_none) else $error("empty queue did not report none");
  property p_freq_rsp;
    emit && emit_query && emit_node == n_cw |=> freq_rsp_req && unit_valid;
  endproperty
  a_freq_rsp: assert property (p_freq_rsp) else $error("frequency query not answered");

  c_unit_data: cover property (unit_valid && unit_has_data && !unit_query);
  c_err_read:  cover property (err_rsp_valid && err_rsp_code != `SMP_ERR_NONE);
  c_full_rel:  cover property (cnt_ff == `SMP_BUF_DEPTH && rel_ff);
  c_common:    cover property (unit_valid && unit_node == n_common);
endmodule : smp_message_parser
`default_nettype wire

// ---- tb/smp_ctrl_model.sv ----
// Remote controller model that sends text program messages one byte at a time.
`timescale 1ns/1ps
`default_nettype none
module smp_ctrl_model (
  input  wire logic      clk,
  input  wire logic      in_ready,
  output var logic       in_valid,
  output var logic [7:0] in_byte,
  output var logic       in_eom
);
  // Idle at time zero so the parser never sees an unknown offer.
  initial
  begin
    in_valid = 1'b0;
    in_byte  = 8'h00;
    in_eom   = 1'b0;
  end

  // Send the text as written, with end-of-message on the last byte if asked.
  // A nonzero gap idles between bytes to model a slow controller.
  task automatic send(input string s, input bit eom, input int gap);
    int i;
    int w;
    @(posedge clk);
    for (i = 0; i < s.len(); i++)
    begin
      #1;
      in_valid = 1'b1;
      in_byte  = s[i];
      in_eom   = eom && (i == s.len() - 1);
      // Hold the byte until an edge that sees room in the buffer.
      w = 0;
      do
      begin
        @(posedge clk);
        w++;
      end
      while (in_ready !== 1'b1 && w < 1000);
      // Released lines show a changed value, so a stale byte is never reread.
      if (gap > 0 && i < s.len() - 1)
      begin
        #1;
        in_valid = 1'b0;
        in_byte  = ~in_byte;
        in_eom   = 1'b0;
        repeat (gap) @(posedge clk);
      end
    end
    #1;
    in_valid = 1'b0;
    in_byte  = ~in_byte;
    in_eom   = 1'b0;
  endtask : send
endmodule : smp_ctrl_model
`default_nettype wire

// ---- tb/smp_message_parser_tb.sv ----
// Self-checking testbench of the program message parser.
`timescale 1ns/1ps
`default_nettype none
`include "smp_map.svh"
module smp_message_parser_tb
  import smp_pkg::*;
;
  logic       clk;
  logic       reset;
  logic       in_valid;
  logic [7:0] in_byte;
  logic       in_eom;
  logic       in_ready;
  logic       unit_valid;
  smp_node_t  unit_node;
  logic       unit_query;
  logic       unit_has_data;
  logic       data_valid;
  logic [7:0] data_byte;
  logic       freq_rsp_req;
  logic       err_rsp_valid;
  logic [7:0] err_rsp_code;
  logic [3:0] err_count;
  int         bad_count = 0;
  int         n_tests   = 0;
  int         cycles    = 0;
  logic [6:0] uq[$];  // Parsed units: node, query, data, freq answer, error answer.
  logic [7:0] cq[$];  // Error codes handed out by error queries.
  logic [7:0] dq[$];  // Parameter data bytes.

  smp_message_parser uut (
    .clk(clk), .reset(reset), .in_valid(in_valid), .in_byte(in_byte), .in_eom(in_eom),
    .in_ready(in_ready), .unit_valid(unit_valid), .unit_node(unit_node),
    .unit_query(unit_query), .unit_has_data(unit_has_data), .data_valid(data_valid),
    .data_byte(data_byte), .freq_rsp_req(freq_rsp_req), .err_rsp_valid(err_rsp_valid),
    .err_rsp_code(err_rsp_code), .err_count(err_count)
  );
  smp_ctrl_model mdl (
    .clk(clk), .in_ready(in_ready), .in_valid(in_valid), .in_byte(in_byte), .in_eom(in_eom)
  );

  // 50 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Pulses last one cycle, so each edge sees every pulse exactly once.
  always @(posedge clk)
  begin
    if (unit_valid === 1'b1)
      uq.push_back({unit_node, unit_query, unit_has_data, freq_rsp_req, err_rsp_valid});
    if (err_rsp_valid === 1'b1)
      cq.push_back(err_rsp_code);
    if (data_valid === 1'b1)
      dq.push_back(data_byte);
  end

  // A hang is cut short well above the few hundred cycles the run needs.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      conclude();
    end
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  function automatic logic [6:0] u(input smp_node_t n, input logic q, input logic d,
                                   input logic f, input logic e);
    return {n, q, d, f, e};
  endfunction : u

  task automatic clr();
    uq.delete();
    cq.delete();
    dq.delete();
  endtask : clr

  // Wait for n units under a bound, then long enough for a full buffer of
  // sixteen bytes and its injected terminator to drain, so late errors and
  // extra units show up before anything is judged.
  task automatic wait_units(input int n);
    int k;
    for (k = 0; k < 300 && uq.size() < n; k++)
      @(posedge clk);
    repeat (24) @(posedge clk);
    check("unit count", 8'(uq.size()), 8'(n));
  endtask : wait_units

  task automatic chk_unit(input logic [6:0] exp);
    check("unit", {1'b0, (uq.size() > 0) ? uq.pop_front() : 7'h7f}, {1'b0, exp});
  endtask : chk_unit

  task automatic chk_code(input logic [7:0] exp);
    check("error code", (cq.size() > 0) ? cq.pop_front() : 8'hff, exp);
  endtask : chk_code

  // Read one stored error through an error query and check the code it returns.
  task automatic pop_err(input logic [7:0] exp);
    clr();
    mdl.send("SYST:ERR?", 1'b1, 0);
    wait_units(1);
    chk_unit(u(n_err, 1'b1, 1'b0, 1'b0, 1'b1));
    chk_code(exp);
  endtask : pop_err

  // Numeric data after a space, sent slowly, with the source subsystem implied.
  task automatic t_data();
    string s;
    int    i;
    s = "1E3";
    clr();
    mdl.send("FREQ 1E3", 1'b1, 2);
    wait_units(1);
    for (i = 0; i < 3; i++)
      check("data", (dq.size() > 0) ? dq.pop_front() : 8'h00, s[i]);
    chk_unit(u(n_freq, 1'b0, 1'b1, 1'b0, 1'b0));
  endtask : t_data

  // Full-path query, then a query with a parameter in the same subsystem.
  task automatic t_query();
    string s;
    int    i;
    s = "MAX";
    clr();
    mdl.send("SOUR:FREQ:CW?;FREQ? MAX", 1'b1, 0);
    wait_units(2);
    chk_unit(u(n_cw, 1'b1, 1'b0, 1'b1, 1'b0));
    chk_unit(u(n_freq, 1'b1, 1'b1, 1'b1, 1'b0));
    for (i = 0; i < 3; i++)
      check("query data", (dq.size() > 0) ? dq.pop_front() : 8'h00, s[i]);
    check("errors", {4'h0, err_count}, 8'h00);
  endtask : t_query

  // Three faulty units queue their codes oldest first; the empty queue reads none.
  task automatic t_errors();
    clr();
    mdl.send("FREQU 1;SYST:ERR;FREQ: CW 5", 1'b1, 0);
    wait_units(0);
    check("errors", {4'h0, err_count}, 8'h03);
    pop_err(`SMP_ERR_HEADER);
    pop_err(`SMP_ERR_QONLY);
    pop_err(`SMP_ERR_SYNTAX);
    pop_err(`SMP_ERR_NONE);
    check("errors", {4'h0, err_count}, 8'h00);
  endtask : t_errors

  // A unit after a semicolon stays in the subsystem unless a colon restarts it.
  task automatic t_tree();
    clr();
    mdl.send("SYST:ERR?;FREQ?;:FREQ?", 1'b1, 0);
    wait_units(2);
    chk_unit(u(n_err, 1'b1, 1'b0, 1'b0, 1'b1));
    chk_unit(u(n_freq, 1'b1, 1'b0, 1'b1, 1'b0));
    check("errors", {4'h0, err_count}, 8'h01);
    pop_err(`SMP_ERR_HEADER);
  endtask : t_tree

  // A common command between tree units leaves the subsystem alone.
  task automatic t_common();
    clr();
    mdl.send("SYST:ERR?;*RST;ERR?", 1'b1, 0);
    wait_units(3);
    chk_unit(u(n_err, 1'b1, 1'b0, 1'b0, 1'b1));
    chk_unit(u(n_common, 1'b0, 1'b0, 1'b0, 1'b0));
    chk_unit(u(n_err, 1'b1, 1'b0, 1'b0, 1'b1));
    check("errors", {4'h0, err_count}, 8'h00);
  endtask : t_common

  // Line feed with end-of-message returns to the root; lower case long form.
  task automatic t_term();
    clr();
    mdl.send("SYST:ERR?\n", 1'b1, 0);
    wait_units(1);
    mdl.send("frequency?", 1'b1, 0);
    wait_units(2);
    chk_unit(u(n_err, 1'b1, 1'b0, 1'b0, 1'b1));
    chk_unit(u(n_freq, 1'b1, 1'b0, 1'b1, 1'b0));
    check("errors", {4'h0, err_count}, 8'h00);
  endtask : t_term

  // A bare line feed waits in the buffer until a later end-of-message.
  task automatic t_lf_only();
    clr();
    mdl.send("FREQ?\n", 1'b0, 0);
    repeat (30) @(posedge clk);
    check("held units", 8'(uq.size()), 8'h00);
    mdl.send("*CLS", 1'b1, 0);
    wait_units(2);
    chk_unit(u(n_freq, 1'b1, 1'b0, 1'b1, 1'b0));
    chk_unit(u(n_common, 1'b0, 1'b0, 1'b0, 1'b0));
  endtask : t_lf_only

  // Verdict and the single end of the run.
  task automatic conclude();
    if (bad_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude

  // Reset for four cycles, then run every scenario.
  initial
  begin
    reset = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    reset = 1'b0;
    check("room after reset", {7'h00, in_ready}, 8'h01);
    t_data();
    t_query();
    t_errors();
    t_tree();
    t_common();
    t_term();
    t_lf_only();
    conclude();
  end
endmodule : smp_message_parser_tb
`default_nettype wire
